// ===== verilog/tsi_pkg.sv
// Constants and types shared by the switch end and the host end of the control link
package tsi_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 16;
    localparam int          STREAMS         = 32;
    localparam int          CHANNELS        = 32;
    localparam int          CM_DEPTH        = STREAMS * CHANNELS;
    localparam int          CM_AW           = 10;
    // Address map: bits 11-10 choose area, bits 9-5 the register
    localparam logic [1:0]  AREA_REG        = 2'h1;
    localparam logic [1:0]  AREA_CM         = 2'h2;
    localparam logic [1:0]  AREA_DM         = 2'h3;
    localparam logic [4:0]  REG_CONTROL     = 5'h00;
    localparam logic [4:0]  REG_FRAME_ALIGN = 5'h01;
    localparam logic [15:0] CONTROL_RESET   = 16'h0000;
    localparam logic [15:0] CONTROL_MASK    = 16'h03FC;
    // Control field positions
    localparam int          CR_ARM          = 9;
    localparam int          CR_PAT_HI       = 8;
    localparam int          CR_PAT_LO       = 5;
    localparam int          CR_START        = 4;
    localparam int          CR_STANDBY      = 3;
    localparam int          CR_EVAL         = 2;
    localparam int          FAR_COMPLETE    = 12;
    // Connection word field positions
    localparam int          CW_LOOPBACK     = 15;
    localparam int          CW_CONSTANT     = 14;
    localparam int          CW_HOST_SRC     = 13;
    localparam int          CW_OUT_EN       = 12;
    localparam int          CW_STREAM_HI    = 11;
    localparam int          CW_STREAM_LO    = 7;
    localparam int          CW_CHAN_HI      = 4;
    localparam int          CW_CHAN_LO      = 0;
    // Frame timing: 8 kHz frame at 40 MHz gives 5000 cycles
    localparam int          FRAME_NS        = 125000;
    localparam int          CLK_NS          = 25;
    localparam int          FRAME_CYCLES    = FRAME_NS / CLK_NS;
    localparam logic [15:0] HOST_GAP_CYCLES = 16'h0003;

    typedef enum logic [2:0] {
        BP_IDLE = 3'b001,
        BP_RUN  = 3'b010,
        BP_DONE = 3'b100
    } bp_state_t;

    typedef enum logic [3:0] {
        EV_IDLE    = 4'b0001,
        EV_MEASURE = 4'b0010,
        EV_DONE    = 4'b0100,
        EV_REARM   = 4'b1000
    } eval_state_t;
endpackage

// ===== verilog/tsi_host_if.sv
// Parallel host port joining the microprocessor end to the switch end
`timescale 1ns/1ps
interface tsi_host_if;
    logic        sel;
    logic        write;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        ack;

    modport switch_end (
        input  sel,
        input  write,
        input  addr,
        input  wdata,
        output rdata,
        output ack
    );
    modport host_end (
        output sel,
        output write,
        output addr,
        output wdata,
        input  rdata,
        input  ack
    );
endinterface

// ===== verilog/tsi_switch.sv
// Switch end: control register, connection memory, block programming, output control
`timescale 1ns/1ps
module tsi_switch
    import tsi_pkg::*;
#(
    parameter int FRAME_LEN = FRAME_CYCLES
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // Host port
    tsi_host_if.switch_end   host,
    // Pins and measurement engine
    input  wire logic        output_drive_pin,
    input  wire logic        frame_eval_complete,
    output logic             frame_eval_run,
    output logic             frame_tick,
    // Per-channel lookup at the serial engine
    input  wire logic [9:0]  tx_slot,
    output logic             slot_drive_n,
    output logic             slot_host_data,
    output logic             slot_constant,
    output logic             slot_loopback,
    output logic [9:0]       slot_source,
    output logic [7:0]       slot_byte,
    output logic             all_outputs_on
);
    logic [DATA_W-1:0] conn_mem [CM_DEPTH];
    logic [15:0]       control,       next_control;
    logic [CM_AW-1:0]  bp_addr,       next_bp_addr;
    bp_state_t         bp_state,      next_bp_state;
    eval_state_t       ev_state,      next_ev_state;
    logic [31:0]       frame_cnt,     next_frame_cnt;
    logic [15:0]       rdata_q,       next_rdata;
    logic              ack_q,         next_ack;
    logic              complete_prev, next_complete_prev;
    logic [15:0]       cm_word;
    logic [15:0]       bp_word;
    logic              host_wr,       ctl_wr,  cm_wr;
    logic              start_rise,    eval_rise, abort;

    function automatic logic is_control(input logic [11:0] a);
        return a[11:10] == AREA_REG && a[9:5] == REG_CONTROL;
    endfunction

    assign host_wr    = host.sel && host.write;
    assign ctl_wr     = host_wr && is_control(host.addr);
    assign cm_wr      = host_wr && host.addr[11:10] == AREA_CM && bp_state != BP_RUN;
    // Start and pattern come from the same write
    assign start_rise = ctl_wr && host.wdata[CR_START] && !control[CR_START];
    assign eval_rise  = ctl_wr && host.wdata[CR_EVAL] && !control[CR_EVAL];
    assign abort      = ctl_wr && (!host.wdata[CR_START] || !host.wdata[CR_ARM]);
    assign bp_word    = {control[CR_PAT_HI:CR_PAT_LO], 12'h000};

    always_comb begin
        next_frame_cnt = (frame_cnt == FRAME_LEN - 1) ? 32'h0 : frame_cnt + 32'h1;
        next_bp_state  = bp_state;
        next_bp_addr   = bp_addr;
        next_control   = control;
        if (ctl_wr) begin
            next_control = host.wdata & CONTROL_MASK;
        end
        case (bp_state)
            BP_IDLE: begin
                if (start_rise && host.wdata[CR_ARM]) begin
                    next_bp_state = BP_RUN;
                    next_bp_addr  = '0;
                end
            end
            BP_RUN: begin
                // One word a cycle: 1024 cycles, far inside two frames
                if (abort) begin
                    next_bp_state = BP_IDLE;
                end else if (bp_addr == CM_AW'(CM_DEPTH - 1)) begin
                    next_bp_state = BP_DONE;
                end else begin
                    next_bp_addr = bp_addr + 10'h001;
                end
            end
            BP_DONE: begin
                // Self-clear wins over a same-cycle write of the start bit
                next_control[CR_START] = 1'b0;
                next_bp_state          = BP_IDLE;
            end
            default: next_bp_state = BP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            control   <= CONTROL_RESET;
            bp_state  <= BP_IDLE;
            bp_addr   <= '0;
            frame_cnt <= '0;
        end else if (clk_en) begin
            control   <= next_control;
            bp_state  <= next_bp_state;
            bp_addr   <= next_bp_addr;
            frame_cnt <= next_frame_cnt;
        end
    end

    // Memory has no reset; host or block programming must fill it
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            if (bp_state == BP_RUN && !abort) begin
                conn_mem[bp_addr] <= bp_word;
            end else if (cm_wr) begin
                conn_mem[host.addr[9:0]] <= host.wdata;
            end
        end
    end

    // Frame evaluation sequencer
    always_comb begin
        next_ev_state      = ev_state;
        next_complete_prev = frame_eval_complete;
        case (ev_state)
            EV_IDLE: begin
                if (eval_rise) begin
                    next_ev_state = EV_MEASURE;
                end
            end
            EV_MEASURE: begin
                if (frame_eval_complete && !complete_prev) begin
                    next_ev_state = EV_DONE;
                end else if (!control[CR_EVAL]) begin
                    next_ev_state = EV_IDLE;
                end
            end
            EV_DONE: begin
                if (!control[CR_EVAL]) begin
                    next_ev_state = EV_REARM;
                end
            end
            EV_REARM: begin
                if (eval_rise) begin
                    next_ev_state = EV_MEASURE;
                end
            end
            default: next_ev_state = EV_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ev_state      <= EV_IDLE;
            complete_prev <= 1'b0;
        end else if (clk_en) begin
            ev_state      <= next_ev_state;
            complete_prev <= next_complete_prev;
        end
    end

    // Host read path, answer one cycle after the request
    always_comb begin
        next_ack   = host.sel;
        next_rdata = rdata_q;
        if (host.sel && !host.write) begin
            case (host.addr[11:10])
                AREA_CM: next_rdata = conn_mem[host.addr[9:0]];
                AREA_REG: begin
                    if (is_control(host.addr)) begin
                        next_rdata = control;
                    end else if (host.addr[9:5] == REG_FRAME_ALIGN) begin
                        next_rdata = 16'(frame_eval_complete) << FAR_COMPLETE;
                    end else begin
                        next_rdata = 16'h0000;
                    end
                end
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 16'h0000;
            ack_q   <= 1'b0;
        end else if (clk_en) begin
            rdata_q <= next_rdata;
            ack_q   <= next_ack;
        end
    end

    // Registered lookup of the word for the slot being transmitted
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cm_word <= 16'h0000;
        end else if (clk_en) begin
            cm_word <= conn_mem[tx_slot];
        end
    end

    assign host.rdata     = rdata_q;
    assign host.ack       = ack_q;
    assign frame_eval_run = ev_state == EV_MEASURE;
    assign frame_tick     = frame_cnt == 32'h0;
    assign all_outputs_on = output_drive_pin || control[CR_STANDBY];
    assign slot_drive_n   = !(all_outputs_on && cm_word[CW_OUT_EN]);
    assign slot_host_data = cm_word[CW_HOST_SRC];
    assign slot_constant  = cm_word[CW_CONSTANT];
    assign slot_loopback  = cm_word[CW_LOOPBACK];
    assign slot_source    = {cm_word[CW_STREAM_HI:CW_STREAM_LO],
                             cm_word[CW_CHAN_HI:CW_CHAN_LO]};
    assign slot_byte      = cm_word[7:0];
endmodule

// ===== verilog/tsi_host.sv
// Host end: microprocessor side that drives the parallel host port
`timescale 1ns/1ps
module tsi_host
    import tsi_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // User command side
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [11:0] cmd_addr,
    input  wire logic [15:0] cmd_wdata,
    output logic             cmd_ready,
    output logic             resp_valid,
    output logic [15:0]      resp_data,
    // Host port
    tsi_host_if.host_end     host
);
    logic        busy,      next_busy;
    logic        sel_q,     next_sel;
    logic        write_q,   next_write;
    logic [11:0] addr_q,    next_addr;
    logic [15:0] wdata_q,   next_wdata;
    logic        rv_q,      next_rv;
    logic [15:0] rd_q,      next_rd;
    logic [15:0] shadow,    next_shadow;
    logic        ctl;

    assign ctl = cmd_addr[11:10] == AREA_REG && cmd_addr[9:5] == REG_CONTROL;

    always_comb begin
        next_busy   = busy;
        next_sel    = 1'b0;
        next_write  = write_q;
        next_addr   = addr_q;
        next_wdata  = wdata_q;
        next_rv     = 1'b0;
        next_rd     = rd_q;
        next_shadow = shadow;
        if (!busy && cmd_valid) begin
            next_busy  = 1'b1;
            next_sel   = 1'b1;
            next_write = cmd_write;
            next_addr  = cmd_addr;
            // Unused bits forced to zero; whole control word in one access
            next_wdata = ctl ? (cmd_wdata & CONTROL_MASK) : (cmd_wdata & 16'hFF9F);
            if (ctl && cmd_write) begin
                next_shadow = cmd_wdata & CONTROL_MASK;
            end
        end else if (busy && host.ack) begin
            next_busy = 1'b0;
            next_rv   = 1'b1;
            next_rd   = host.rdata;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy    <= 1'b0;
            sel_q   <= 1'b0;
            write_q <= 1'b0;
            addr_q  <= 12'h000;
            wdata_q <= 16'h0000;
            rv_q    <= 1'b0;
            rd_q    <= 16'h0000;
            shadow  <= CONTROL_RESET;
        end else if (clk_en) begin
            busy    <= next_busy;
            sel_q   <= next_sel;
            write_q <= next_write;
            addr_q  <= next_addr;
            wdata_q <= next_wdata;
            rv_q    <= next_rv;
            rd_q    <= next_rd;
            shadow  <= next_shadow;
        end
    end

    // Frame pacing of start-bit and evaluation sequences is the software's job
    assign cmd_ready   = !busy;
    assign resp_valid  = rv_q;
    assign resp_data   = rd_q;
    assign host.sel    = sel_q;
    assign host.write  = write_q;
    assign host.addr   = addr_q;
    assign host.wdata  = wdata_q;
endmodule

// ===== test/tsi_link_properties.sv
// Bus-level checks of the switch end's control and connection words
`timescale 1ns/1ps
module tsi_link_properties
    import tsi_pkg::*;
#(
    parameter int FRAME_LEN = FRAME_CYCLES
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    // Host port
    input wire logic        sel,
    input wire logic        write,
    input wire logic [11:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic        ack
);
    // Fill takes 1024 cycles; small margin for the self-clear
    localparam int BP_END = 1030;
    logic        wr_ctl;
    logic        rd_ctl;
    logic        rd_far;
    logic        wr_cm;
    logic        rd_cm;
    logic        bp_on;
    logic        bp_busy;
    logic        cm_ok;
    logic        cm_since;
    int          bp_cnt;
    logic [15:0] ctl_seen;
    logic [15:0] cm_data;
    logic [9:0]  cm_slot;

    assign wr_ctl  = sel & write & (addr[11:10] == AREA_REG) & (addr[9:5] == REG_CONTROL);
    assign rd_ctl  = sel & !write & (addr[11:10] == AREA_REG) & (addr[9:5] == REG_CONTROL);
    assign rd_far  = sel & !write & (addr[11:10] == AREA_REG) & (addr[9:5] == REG_FRAME_ALIGN);
    assign wr_cm   = sel & write & (addr[11:10] == AREA_CM);
    assign rd_cm   = sel & !write & (addr[11:10] == AREA_CM);
    assign bp_busy = bp_on & (bp_cnt < BP_END);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bp_on    <= 1'b0;
            bp_cnt   <= 0;
            ctl_seen <= 16'h0000;
            cm_ok    <= 1'b0;
            cm_since <= 1'b0;
            cm_data  <= 16'h0000;
            cm_slot  <= 10'h000;
        end else begin
            if (bp_on && bp_cnt < 2 * FRAME_LEN) begin
                bp_cnt <= bp_cnt + 1;
            end
            if (wr_ctl) begin
                ctl_seen <= wdata;
                if (wdata[CR_START] && wdata[CR_ARM] && !bp_busy && !ctl_seen[CR_START]) begin
                    bp_on    <= 1'b1;
                    bp_cnt   <= 0;
                    cm_ok    <= 1'b0;
                    cm_since <= 1'b0;
                end else if (!wdata[CR_START] || !wdata[CR_ARM]) begin
                    bp_on <= 1'b0;
                end
            end
            // Writes during a fill are refused, so they are not tracked
            if (wr_cm && !bp_busy) begin
                cm_ok    <= 1'b1;
                cm_since <= 1'b1;
                cm_slot  <= addr[9:0];
                cm_data  <= wdata;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_ctl_read;
        rd_ctl ##1 ack;
    endsequence

    chk_ack_pulse: assert property (sel |=> ack ##1 !ack)
        else $error("ack not a single pulse after request");
    chk_unused_zero: assert property (s_ctl_read |-> rdata[15:10] == 6'h00 && rdata[1:0] == 2'h0)
        else $error("unused control bits read nonzero");
    chk_fields_kept: assert property (s_ctl_read |-> (rdata & 16'h03EC) == (ctl_seen & 16'h03EC))
        else $error("control fields differ from last write");
    chk_start_held: assert property (rd_ctl && bp_on && bp_cnt < 1000 |=> rdata[CR_START])
        else $error("start bit low during fill");
    chk_start_clear: assert property (rd_ctl && (!ctl_seen[CR_START] || bp_on && bp_cnt >= 2 * FRAME_LEN) |=> !rdata[CR_START])
        else $error("start bit still high");
    chk_word_back: assert property (rd_cm && cm_ok && addr[9:0] == cm_slot |=> rdata == cm_data)
        else $error("connection word readback differs");
    chk_block_fill: assert property (rd_cm && bp_on && bp_cnt >= BP_END && !cm_since |=> rdata == {ctl_seen[CR_PAT_HI:CR_PAT_LO], 12'h000})
        else $error("filled word differs from pattern");
    chk_align_bits: assert property (rd_far |=> rdata[15:13] == 3'h0 && rdata[11:0] == 12'h000)
        else $error("frame align register spare bits set");
endmodule

// ===== test/tb_tsi_connection_control.sv
// Self-checking bench for both ends of the switch control link
`timescale 1ns/1ps
module tb_tsi_connection_control;
    import tsi_pkg::*;
    localparam int          FL  = 1000;
    localparam logic [11:0] CTL = {AREA_REG, REG_CONTROL, 5'h00};
    logic        sys_clk = 0;
    logic        reset_n = 0;
    logic        clk_en = 1;
    logic        cmd_valid = 0;
    logic        cmd_write = 0;
    logic [11:0] cmd_addr = 0;
    logic [15:0] cmd_wdata = 0;
    logic        cmd_ready, resp_valid, frame_eval_run, all_outputs_on;
    logic [15:0] resp_data, rd;
    logic        output_drive_pin = 0;
    logic        frame_eval_complete = 0;
    logic [9:0]  tx_slot = 0;
    logic        slot_drive_n, slot_host_data, slot_constant, slot_loopback, frame_tick;
    logic [9:0]  slot_source;
    logic [7:0]  slot_byte;
    logic [15:0] w;
    logic [15:0] words[3] = '{16'hB885, 16'h4F9F, 16'h1000};
    logic [9:0]  slots[3] = '{10'h000, 10'h3FF, 10'h155};
    int          err_count = 0;
    int          compares = 0;
    int          cyc = 0;
    int          n = 0;

    tsi_host_if i_tsi_host_if ();
    tsi_switch #(.FRAME_LEN(FL)) i_tsi_switch (.sys_clk(sys_clk), .reset_n(reset_n),
        .clk_en(clk_en), .host(i_tsi_host_if), .output_drive_pin(output_drive_pin),
        .frame_eval_complete(frame_eval_complete), .frame_eval_run(frame_eval_run),
        .frame_tick(frame_tick), .tx_slot(tx_slot), .slot_drive_n(slot_drive_n),
        .slot_host_data(slot_host_data), .slot_constant(slot_constant),
        .slot_loopback(slot_loopback), .slot_source(slot_source), .slot_byte(slot_byte),
        .all_outputs_on(all_outputs_on));
    tsi_host i_tsi_host (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_data(resp_data), .host(i_tsi_host_if));
    tsi_link_properties #(.FRAME_LEN(FL)) i_tsi_link_properties (.sys_clk(sys_clk),
        .reset_n(reset_n), .sel(i_tsi_host_if.sel), .write(i_tsi_host_if.write),
        .addr(i_tsi_host_if.addr), .wdata(i_tsi_host_if.wdata),
        .rdata(i_tsi_host_if.rdata), .ack(i_tsi_host_if.ack));

    always #12.5 sys_clk = ~sys_clk;

    task automatic report_and_stop;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hangs are caught by the cycle ceiling, not per access
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic acc(input logic wr, input logic [11:0] a, input logic [15:0] d);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr  <= a;
        cmd_wdata <= d;
        do @(posedge sys_clk); while (!cmd_ready);
        cmd_valid <= 1'b0;
        do @(posedge sys_clk); while (!resp_valid);
        rd = resp_data;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        acc(0, CTL, 0);
        chk("control", CONTROL_RESET, rd);
        acc(1, CTL, 16'hFDEB);
        acc(0, CTL, 0);
        chk("control", 16'h01E8, rd);
        for (int i = 0; i < 3; i++) begin
            w = words[i];
            acc(1, {AREA_CM, slots[i]}, w);
            acc(0, {AREA_CM, slots[i]}, 0);
            chk("word", w, rd);
            tx_slot <= slots[i];
            for (int j = 0; j < 4; j++) begin
                output_drive_pin <= j[0];
                acc(1, CTL, {12'h000, j[1], 3'h0});
                repeat (2) @(posedge sys_clk);
                chk("all_on", 16'(j[0] | j[1]), 16'(all_outputs_on));
                chk("drive_n", 16'(!((j[0] | j[1]) & w[12])), 16'(slot_drive_n));
            end
            chk("source", {6'h00, w[11:7], w[4:0]}, {6'h00, slot_source});
            chk("byte", {8'h00, w[7:0]}, {8'h00, slot_byte});
            chk("flags", {13'h0, w[15:13]},
                {13'h0, slot_loopback, slot_constant, slot_host_data});
        end
        acc(1, CTL, 16'h0004);
        repeat (2) @(posedge sys_clk);
        chk("eval_run", 16'h0001, 16'(frame_eval_run));
        frame_eval_complete <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("eval_run", 16'h0000, 16'(frame_eval_run));
        acc(0, {AREA_REG, REG_FRAME_ALIGN, 5'h00}, 0);
        chk("align", 16'h1000, rd);
        acc(1, CTL, 0);
        frame_eval_complete <= 1'b0;
        repeat (FL) @(posedge sys_clk);
        // Second run after a frame at zero, then cleared while measuring
        acc(1, CTL, 16'h0004);
        repeat (2) @(posedge sys_clk);
        chk("eval_rerun", 16'h0001, 16'(frame_eval_run));
        acc(1, CTL, 16'h0000);
        chk("eval_stop", 16'h0000, 16'(frame_eval_run));
        acc(1, CTL, 16'h0350);
        acc(1, {AREA_CM, 10'h005}, 16'h1234);
        acc(0, CTL, 0);
        chk("control", 16'h0350, rd);
        repeat (2 * FL) @(posedge sys_clk);
        acc(0, CTL, 0);
        chk("control", 16'h0340, rd);
        for (int i = 0; i < 3; i++) begin
            acc(0, {AREA_CM, slots[i] ^ 10'h005}, 0);
            chk("fill", 16'hA000, rd);
        end
        // Abort part way: early slots take the new pattern, late ones keep the old
        acc(1, CTL, 16'h02B0);
        repeat (100) @(posedge sys_clk);
        acc(1, CTL, 16'h02A0);
        acc(0, CTL, 0);
        chk("control", 16'h02A0, rd);
        acc(0, {AREA_CM, 10'h000}, 0);
        chk("fill", 16'h5000, rd);
        acc(1, CTL, 16'h02B0);
        repeat (50) @(posedge sys_clk);
        acc(1, CTL, 16'h00B0);
        repeat (2 * FL) @(posedge sys_clk);
        acc(0, {AREA_CM, 10'h3FF}, 0);
        chk("fill", 16'hA000, rd);
        // Frame period, then stretched by ten cycles of frozen clock enable
        do @(posedge sys_clk); while (!frame_tick);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!frame_tick);
        chk("frame_len", 16'(FL), 16'(n));
        clk_en <= 1'b0;
        repeat (10) @(posedge sys_clk);
        clk_en <= 1'b1;
        n = 10;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!frame_tick);
        chk("frozen_len", 16'(FL + 10), 16'(n));
        report_and_stop();
    end
endmodule
